// ===== pkg/wdg_lock_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wdg_lock_if;
   logic       wr_any;
   logic       wr_ctl;
   logic       wr_upper;
   logic       wr_high;
   logic       wr_low;
   logic [7:0] wdata;
   logic       ld_upper;
   logic       ld_high;
   logic       ld_low;
   logic       stop_cfg_we;
   logic       stop_cfg_val;
   modport bus (output wr_any, wr_ctl, wr_upper, wr_high, wr_low, wdata,
                input  ld_upper, ld_high, ld_low, stop_cfg_we, stop_cfg_val);
   modport fsm (input  wr_any, wr_ctl, wr_upper, wr_high, wr_low, wdata,
                output ld_upper, ld_high, ld_low, stop_cfg_we, stop_cfg_val);
endinterface : wdg_lock_if
`default_nettype wire

// ===== pkg/wdg_pkg.sv
package wdg_pkg;

   // ==========================================================
   // clocking
   // ==========================================================
   localparam int unsigned CORE_CLK_HZ = 125_000_000;
   // nominal rate of the watchdog oscillator, in Hz
   localparam int unsigned RC_OSC_HZ   = 10_000;
   localparam int unsigned RC_DIV      = CORE_CLK_HZ / RC_OSC_HZ;

   // ==========================================================
   // register map
   // ==========================================================
   localparam int unsigned ADDR_W       = 12;
   localparam logic [11:0] CTL_OFS      = 12'hFF0;
   localparam logic [11:0] UPPER_OFS    = 12'hFF1;
   localparam logic [11:0] HIGH_OFS     = 12'hFF2;
   localparam logic [11:0] LOW_OFS      = 12'hFF3;

   // control register fields
   localparam int unsigned CTL_POR_BIT  = 7;
   localparam int unsigned CTL_STOP_BIT = 6;
   localparam int unsigned CTL_WDT_BIT  = 5;
   localparam int unsigned CTL_EXT_BIT  = 4;
   localparam int unsigned CTL_SM_BIT   = 0;
   localparam logic [3:0]  CTL_FLAG_RST = 4'h8;

   // reload and counter values
   localparam logic [23:0] RELOAD_RST   = 24'h00FFFF;
   localparam logic [23:0] REFRESH_LAST = 24'h000002;
   localparam logic [23:0] COUNT_ONE    = 24'h000001;

   // ==========================================================
   // lock sequence codes
   // ==========================================================
   localparam logic [7:0]  UNLOCK_FIRST  = 8'h55;
   localparam logic [7:0]  UNLOCK_SECOND = 8'hAA;
   localparam logic [7:0]  STOP_HALT     = 8'h81;
   localparam logic [7:0]  STOP_RUN      = 8'h00;

   typedef enum logic [2:0] {
      WDG_LK_IDLE = 3'b000,
      WDG_LK_55   = 3'b001,
      WDG_LK_OPEN = 3'b010,
      WDG_LK_HIGH = 3'b011,
      WDG_LK_LOW  = 3'b100
   } wdg_lock_t;

endpackage : wdg_pkg

// ===== rtl/wdg_tick.sv
`timescale 1ns/1ps
`default_nettype none
module wdg_tick #(
   parameter int unsigned DIV = 12500
) (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // control
   input  wire logic run,
   // one-cycle oscillator tick
   output logic      tick
);
   localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } wdg_tick_st_t;

   wdg_tick_st_t s_reg;
   wdg_tick_st_t s_next;

   // divider restarts whenever the oscillator is stopped
   always_comb begin
      s_next      = s_reg;
      s_next.tick = 1'b0;
      if (!run) begin
         s_next.cnt = '0;
      end else if (s_reg.cnt == CW'(DIV - 1)) begin
         s_next.cnt  = '0;
         s_next.tick = 1'b1;
      end else begin
         s_next.cnt = s_reg.cnt + CW'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick = s_reg.tick;
endmodule : wdg_tick
`default_nettype wire

// ===== rtl/wdg_top.sv
`timescale 1ns/1ps
`default_nettype none
module wdg_top #(
   parameter int unsigned RC_DIV = wdg_pkg::RC_DIV
) (
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      rst_n,
   // register port
   input  wire logic [wdg_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]                reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic      [7:0]                reg_rdata,
   // processor state
   input  wire logic                      refresh_instruction,
   input  wire logic                      debug_mode,
   input  wire logic                      stop_mode,
   // option bits
   input  wire logic                      always_on_option,
   input  wire logic                      timeout_response_option,
   // time-out responses
   output logic                           irq_req,
   output logic                           reset_req,
   output logic                           stop_recovery,
   // status
   output logic                           watchdog_on,
   output logic                           rc_osc_run
);
   import wdg_pkg::*;

   // ==========================================================
   // state
   // ==========================================================
   typedef struct packed {
      logic        on;
      logic        osc;
      logic [23:0] count;
      logic [7:0]  reload_upper_byte;
      logic [7:0]  reload_high_byte;
      logic [7:0]  reload_low_byte;
      logic [3:0]  flags;
      logic        stop_halt;
      logic        refresh_pend;
      logic        irq;
      logic        rst_req;
      logic        smr;
      logic [7:0]  rdata;
   } wdg_top_st_t;

   wdg_top_st_t s_reg;
   wdg_top_st_t s_next;

   // flag nibble positions, relative to the control register's bit 4
   localparam int unsigned FP = CTL_POR_BIT - CTL_EXT_BIT;
   localparam int unsigned FS = CTL_STOP_BIT - CTL_EXT_BIT;
   localparam int unsigned FW = CTL_WDT_BIT - CTL_EXT_BIT;

   logic        tick;
   logic [23:0] reload_value;
   logic        sel_ctl;
   logic        sel_upper;
   logic        sel_high;
   logic        sel_low;
   logic        timeout;
   logic        refresh_ok;
   logic [7:0]  ctl_view;

   // ==========================================================
   // oscillator tick
   // ==========================================================
   // the oscillator is emulated by a divider of the core clock;
   // a real oscillator would need a synchroniser here instead
   wdg_tick #(
      .DIV  (RC_DIV)
   ) u_tick (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .run      (s_reg.osc),
      .tick     (tick)
   );

   // ==========================================================
   // lock sequence
   // ==========================================================
   wdg_lock_if lock_bus ();

   assign sel_ctl   = (reg_addr == CTL_OFS);
   assign sel_upper = (reg_addr == UPPER_OFS);
   assign sel_high  = (reg_addr == HIGH_OFS);
   assign sel_low   = (reg_addr == LOW_OFS);

   assign lock_bus.wr_any   = reg_wr;
   assign lock_bus.wr_ctl   = reg_wr && sel_ctl;
   assign lock_bus.wr_upper = reg_wr && sel_upper;
   assign lock_bus.wr_high  = reg_wr && sel_high;
   assign lock_bus.wr_low   = reg_wr && sel_low;
   assign lock_bus.wdata    = reg_wdata;

   wdg_unlock u_unlock (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .lk       (lock_bus)
   );

   // ==========================================================
   // counter helpers
   // ==========================================================
   assign reload_value = {s_reg.reload_upper_byte,
                          s_reg.reload_high_byte,
                          s_reg.reload_low_byte};

   // at a count of two or below a refresh would race the time-out, so it is not taken
   assign refresh_ok = (s_reg.count > REFRESH_LAST);

   assign timeout = s_reg.on && tick && !((s_reg.refresh_pend || debug_mode) && refresh_ok)
                    && (s_reg.count == COUNT_ONE);

   assign ctl_view = {s_reg.flags, 3'b000, s_reg.stop_halt};

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      s_next         = s_reg;
      s_next.irq     = 1'b0;
      s_next.rst_req = 1'b0;
      s_next.smr     = 1'b0;
      s_next.rdata   = 8'h00;

      // ---- enable: never turns off again ----
      if (!s_reg.on) begin
         if (refresh_instruction || always_on_option) begin
            s_next.on           = 1'b1;
            s_next.count        = reload_value;
            s_next.refresh_pend = 1'b0;
         end
      end else begin
         // requests are held until the next oscillator tick; one that arrives in a tick cycle is dropped
         if (refresh_instruction) begin
            s_next.refresh_pend = 1'b1;
         end
         if (tick) begin
            s_next.refresh_pend = 1'b0;
            if ((s_reg.refresh_pend || debug_mode) && refresh_ok) begin
               s_next.count = reload_value;
            end else begin
               // wraps through zero to all ones and keeps going
               s_next.count = s_reg.count - COUNT_ONE;
            end
         end
      end

      // ---- oscillator gating in stop ----
      s_next.osc = s_next.on && !(stop_mode && s_reg.stop_halt);

      // ---- stop configuration through the lock sequence ----
      if (lock_bus.stop_cfg_we) begin
         s_next.stop_halt = lock_bus.stop_cfg_val;
      end

      // ---- reload bytes, only when unlocked ----
      if (lock_bus.ld_upper) begin
         s_next.reload_upper_byte = reg_wdata;
      end
      if (lock_bus.ld_high) begin
         s_next.reload_high_byte = reg_wdata;
      end
      if (lock_bus.ld_low) begin
         s_next.reload_low_byte = reg_wdata;
      end

      // ---- register reads ----
      if (reg_rd) begin
         if (sel_ctl) begin
            s_next.rdata = ctl_view;
            s_next.flags = 4'h0;
         end else if (sel_upper) begin
            s_next.rdata = s_reg.reload_upper_byte;
         end else if (sel_high) begin
            s_next.rdata = s_reg.reload_high_byte;
         end else if (sel_low) begin
            s_next.rdata = s_reg.reload_low_byte;
         end else begin
            s_next.rdata = 8'h00;
         end
      end

      // ---- time-out response; placed after the read so a set wins ----
      if (timeout) begin
         s_next.flags[FW] = 1'b1;
         if (stop_mode) begin
            s_next.smr       = 1'b1;
            s_next.flags[FS] = 1'b1;
            s_next.flags[FP] = 1'b0;
            if (!timeout_response_option) begin
               s_next.irq = 1'b1;
            end
         end else if (timeout_response_option) begin
            s_next.rst_req   = 1'b1;
            s_next.flags[FS] = 1'b0;
         end else begin
            s_next.irq = 1'b1;
         end
      end
   end

   // ==========================================================
   // state register
   // ==========================================================
   // control writes never reach flags; only the lock path sees them
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_reg                   <= '0;
         s_reg.reload_upper_byte <= RELOAD_RST[23:16];
         s_reg.reload_high_byte  <= RELOAD_RST[15:8];
         s_reg.reload_low_byte   <= RELOAD_RST[7:0];
         s_reg.flags             <= CTL_FLAG_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign reg_rdata     = s_reg.rdata;
   assign irq_req       = s_reg.irq;
   assign reset_req     = s_reg.rst_req;
   assign stop_recovery = s_reg.smr;
   assign watchdog_on   = s_reg.on;
   assign rc_osc_run    = s_reg.osc;

endmodule : wdg_top
`default_nettype wire

// ===== rtl/wdg_unlock.sv
`timescale 1ns/1ps
`default_nettype none
module wdg_unlock (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // write stream and load strobes
   wdg_lock_if.fsm  lk
);
   import wdg_pkg::*;

   typedef struct packed {
      wdg_lock_t st;
   } wdg_unlock_st_t;

   wdg_unlock_st_t s_reg;
   wdg_unlock_st_t s_next;

   always_comb begin
      s_next          = s_reg;
      lk.ld_upper     = 1'b0;
      lk.ld_high      = 1'b0;
      lk.ld_low       = 1'b0;
      lk.stop_cfg_we  = 1'b0;
      lk.stop_cfg_val = (lk.wdata == STOP_HALT);
      if (lk.wr_any) begin
         // any write off the expected path drops the lock
         s_next.st = WDG_LK_IDLE;
         case (s_reg.st)
            WDG_LK_55: begin
               if (lk.wr_ctl && lk.wdata == UNLOCK_SECOND) s_next.st = WDG_LK_OPEN;
            end
            WDG_LK_OPEN: begin
               if (lk.wr_ctl && (lk.wdata == STOP_HALT || lk.wdata == STOP_RUN)) begin
                  lk.stop_cfg_we = 1'b1;
               end else if (lk.wr_upper) begin
                  lk.ld_upper = 1'b1;
                  s_next.st   = WDG_LK_HIGH;
               end
            end
            WDG_LK_HIGH: begin
               if (lk.wr_high) begin
                  lk.ld_high = 1'b1;
                  s_next.st  = WDG_LK_LOW;
               end
            end
            WDG_LK_LOW: begin
               if (lk.wr_low) lk.ld_low = 1'b1;
            end
            default: begin
               s_next.st = WDG_LK_IDLE;
            end
         endcase
         // a fresh first code always restarts the sequence
         if (s_next.st == WDG_LK_IDLE && lk.wr_ctl && lk.wdata == UNLOCK_FIRST) s_next.st = WDG_LK_55;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_reg.st <= WDG_LK_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule : wdg_unlock
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
   $display("[ERR] %0t: got %0h want %0h", $time, (got), (exp)); end end
module tb;
   import wdg_pkg::*;
   localparam int unsigned DIV = 4;
   // ==========================================================
   // signals
   // ==========================================================
   logic [ADDR_W-1:0] reg_addr   = 12'h000;
   logic [7:0]        reg_wdata  = 8'h00;
   logic [7:0]        reg_rdata;
   logic              core_clk   = 1'h0;
   logic              rst_n      = 1'h0;
   logic              reg_wr     = 1'h0;
   logic              reg_rd     = 1'h0;
   logic              debug_mode = 1'h0;
   logic              stop_mode  = 1'h0;
   logic              aon        = 1'h0;
   logic              resp_opt   = 1'h0;
   logic              refresh_instruction;
   logic              irq_req;
   logic              reset_req;
   logic              stop_recovery;
   logic              watchdog_on;
   logic              rc_osc_run;
   int                failures     = 0;
   int                total_checks = 0;
   int                cyc          = 0;
   int                k;
   wdg_top #(.RC_DIV(DIV)) uut (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .refresh_instruction(refresh_instruction), .debug_mode(debug_mode), .stop_mode(stop_mode),
      .always_on_option(aon), .timeout_response_option(resp_opt), .irq_req(irq_req),
      .reset_req(reset_req), .stop_recovery(stop_recovery), .watchdog_on(watchdog_on),
      .rc_osc_run(rc_osc_run)
   );
   wdg_cpu_model cpu (
      .core_clk(core_clk), .rst_n(rst_n), .irq_req(irq_req), .reset_req(reset_req),
      .stop_recovery(stop_recovery), .refresh_instruction(refresh_instruction)
   );
   always #4 core_clk = ~core_clk;
   // the tests need about twelve hundred cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         failures++;
         $display("[ERR] %0t: run timed out", $time);
         end_sim();
      end
   end
   // ==========================================================
   // tasks
   // ==========================================================
   task automatic end_sim();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic do_reset();
      @(posedge core_clk);
      rst_n      <= 1'h0;
      reg_wr     <= 1'h0;
      reg_rd     <= 1'h0;
      aon        <= 1'h0;
      debug_mode <= 1'h0;
      stop_mode  <= 1'h0;
      resp_opt   <= 1'h0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'h1;
   endtask : do_reset
   // strobe stays up so writes can follow back to back
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'h1;
      reg_rd    <= 1'h0;
      reg_addr  <= a;
      reg_wdata <= d;
   endtask : wr
   task automatic idle();
      @(posedge core_clk);
      reg_wr <= 1'h0;
   endtask : idle
   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_wr   <= 1'h0;
      reg_rd   <= 1'h1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1;
      `CHK(reg_rdata, e)
   endtask : rdc
   task automatic load(input logic [23:0] v);
      wr(CTL_OFS, UNLOCK_FIRST);
      wr(CTL_OFS, UNLOCK_SECOND);
      wr(UPPER_OFS, v[23:16]);
      wr(HIGH_OFS, v[15:8]);
      wr(LOW_OFS, v[7:0]);
      idle();
   endtask : load
   task automatic wait_resp(input int lim, output int n);
      n = 0;
      do begin
         @(posedge core_clk);
         #1 n++;
      end while (!(irq_req | reset_req | stop_recovery) && n < lim);
   endtask : wait_resp
   // ==========================================================
   // tests
   // ==========================================================
   initial begin
      do_reset();
      load(24'h123456);
      rdc(CTL_OFS, 8'h80);
      rdc(CTL_OFS, 8'h00);
      rdc(UPPER_OFS, 8'h12);
      rdc(HIGH_OFS, 8'h34);
      rdc(LOW_OFS, 8'h56);
      wr(UPPER_OFS, 8'h77);
      wr(CTL_OFS, UNLOCK_FIRST);
      wr(12'h100, 8'h00);
      wr(CTL_OFS, UNLOCK_SECOND);
      wr(UPPER_OFS, 8'h77);
      rdc(UPPER_OFS, 8'h12);
      load(24'h770000);
      wr(12'h100, 8'h00);
      wr(HIGH_OFS, 8'h77);
      rdc(UPPER_OFS, 8'h77);
      rdc(HIGH_OFS, 8'h00);
      rdc(12'h100, 8'h00);
      $display("test lock done");
      for (int s = 0; s < 4; s++) begin
         do_reset();
         load(24'h000004);
         stop_mode <= s[1];
         resp_opt  <= s[0];
         cpu.refresh();
         wait_resp(200, k);
         `CHK((k >= 4 * DIV) && (k <= 4 * DIV + 3), 1'h1)
         repeat (100) @(posedge core_clk);
         `CHK(cpu.n_irq, int'(!s[0]))
         `CHK(cpu.n_rst, int'(s == 1))
         `CHK(cpu.n_stop, int'(s[1]))
         rdc(CTL_OFS, s[1] ? 8'h60 : 8'hA0);
         rdc(CTL_OFS, 8'h00);
      end
      $display("test time-out done");
      do_reset();
      load(24'h000004);
      cpu.refresh();
      repeat (2 * DIV + 1) @(posedge core_clk);
      cpu.refresh();
      wait_resp(200, k);
      `CHK((k >= 2 * DIV - 2) && (k <= 2 * DIV + 1), 1'h1)
      $display("test late refresh done");
      do_reset();
      load(24'h000008);
      repeat (20) begin
         cpu.refresh();
         repeat (2 * DIV - 2) @(posedge core_clk);
      end
      `CHK(cpu.n_irq, 0)
      wait_resp(400, k);
      `CHK((k >= 6 * DIV) && (k <= 7 * DIV + 4), 1'h1)
      $display("test refresh done");
      do_reset();
      load(24'h000004);
      aon        <= 1'h1;
      debug_mode <= 1'h1;
      repeat (40 * DIV) @(posedge core_clk);
      `CHK(cpu.n_irq, 0)
      `CHK(watchdog_on, 1'h1)
      debug_mode <= 1'h0;
      wait_resp(200, k);
      `CHK((k >= 3 * DIV) && (k <= 5 * DIV + 3), 1'h1)
      $display("test debug done");
      do_reset();
      load(24'h000004);
      wr(CTL_OFS, UNLOCK_FIRST);
      wr(CTL_OFS, UNLOCK_SECOND);
      wr(CTL_OFS, STOP_HALT);
      idle();
      stop_mode <= 1'h1;
      cpu.refresh();
      repeat (30 * DIV) @(posedge core_clk);
      `CHK(rc_osc_run, 1'h0)
      `CHK(cpu.n_stop, 0)
      rdc(CTL_OFS, 8'h81);
      wr(CTL_OFS, UNLOCK_FIRST);
      wr(CTL_OFS, UNLOCK_SECOND);
      wr(CTL_OFS, STOP_RUN);
      rdc(CTL_OFS, 8'h00);
      wait_resp(200, k);
      `CHK(stop_recovery, 1'h1)
      $display("test stop halt done");
      end_sim();
   end
endmodule : tb
`default_nettype wire

// ===== sim/wdg_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module wdg_cpu_model (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // watchdog responses
   input  wire logic irq_req,
   input  wire logic reset_req,
   input  wire logic stop_recovery,
   // refresh request
   output var logic  refresh_instruction
);
   // ==========================================================
   // response counters, cleared with the block
   // ==========================================================
   int n_irq  = 0;
   int n_rst  = 0;
   int n_stop = 0;
   initial refresh_instruction = 1'h0;
   always @(posedge core_clk) begin
      if (!rst_n) begin
         n_irq  <= 0;
         n_rst  <= 0;
         n_stop <= 0;
      end else begin
         n_irq  <= n_irq + int'(irq_req);
         n_rst  <= n_rst + int'(reset_req);
         n_stop <= n_stop + int'(stop_recovery);
      end
   end
   // one instruction, held across exactly one taking edge
   task automatic refresh();
      @(posedge core_clk);
      refresh_instruction <= 1'h1;
      @(posedge core_clk);
      refresh_instruction <= 1'h0;
   endtask : refresh
endmodule : wdg_cpu_model
`default_nettype wire

// ===== sim/wdg_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module wdg_top_asserts #(
   parameter int unsigned RC_DIV = 4
) (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rst_n,
   // register read port
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // processor state and options
   input wire logic       refresh_instruction,
   input wire logic       debug_mode,
   input wire logic       stop_mode,
   input wire logic       always_on_option,
   input wire logic       timeout_response_option,
   // responses and status
   input wire logic       irq_req,
   input wire logic       reset_req,
   input wire logic       stop_recovery,
   input wire logic       watchdog_on,
   input wire logic       rc_osc_run
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // debug hold counter
   // ==========================================================
   logic [15:0] dbg_reg;
   logic [15:0] dbg_next;
   // saturates so a long debug session never wraps back to zero
   assign dbg_next = !debug_mode ? 16'h0000 : (dbg_reg == 16'hFFFF ? dbg_reg : dbg_reg + 16'h0001);
   always_ff @(posedge core_clk) dbg_reg <= rst_n ? dbg_next : 16'h0000;
   // ==========================================================
   // properties
   // ==========================================================
   AST_ENABLE: assert property (!watchdog_on && (refresh_instruction || always_on_option) |=> watchdog_on)
      else $error("watchdog not enabled");
   AST_STAYS_ON: assert property (watchdog_on |=> watchdog_on)
      else $error("watchdog turned off");
   AST_IRQ_MODE: assert property (irq_req |-> !timeout_response_option && watchdog_on)
      else $error("interrupt in reset response mode");
   AST_RST_MODE: assert property (reset_req |-> timeout_response_option && !stop_mode)
      else $error("reset request out of place");
   AST_STOP_SRC: assert property (stop_recovery |-> stop_mode && !reset_req)
      else $error("stop recovery out of place");
   AST_STOP_IRQ: assert property (stop_recovery && !timeout_response_option |-> irq_req)
      else $error("stop recovery without interrupt");
   AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   AST_RUN_AWAKE: assert property (watchdog_on && !stop_mode |=> rc_osc_run)
      else $error("oscillator halted outside stop");
   // three ticks of margin: a count already at two still runs out
   AST_DEBUG_HOLD: assert property (dbg_reg > 3 * RC_DIV + 4 |-> !(irq_req || reset_req || stop_recovery))
      else $error("time-out during debug");
   cover property (irq_req && !stop_recovery);
   cover property (reset_req);
   cover property (stop_recovery && irq_req);
   cover property (dbg_reg > 3 * RC_DIV + 4);
endmodule : wdg_top_asserts
bind wdg_top wdg_top_asserts #(.RC_DIV(RC_DIV)) u_wdg_asserts (
   .core_clk(core_clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .refresh_instruction(refresh_instruction), .debug_mode(debug_mode), .stop_mode(stop_mode),
   .always_on_option(always_on_option), .timeout_response_option(timeout_response_option),
   .irq_req(irq_req), .reset_req(reset_req), .stop_recovery(stop_recovery),
   .watchdog_on(watchdog_on), .rc_osc_run(rc_osc_run)
);
`default_nettype wire
